// ### rtl/tsiic_port.sv
// Sensor two-wire slave port with register selector and byte queue
// Notes on behaviour
// - SDA falling while SCL high starts transaction
// - SDA rising while SCL high stops transaction
// - Start or stop mid-byte releases data line
// - Port is slave only, never drives clock
// - Address is 0011 plus three strap pins
// - Acknowledge address only on full match
// - Last address bit: one read, zero write
// - Acknowledge every byte received once addressed, unless the byte queue is full
// - Acknowledge low across the whole ninth clock
// - After not-acknowledge, data line stays released
// - Clock stuck high or low resets interface
// - Eight-bit write-only pointer selects register
// - Pointer codes one to seven name registers
// - Ambient read is coherent, refreshed per conversion
// - Limits read/write; upper or lower limit excursion raises alert output
// - Pointer kept across transactions
// - No pointer auto-increment; one register each
// - Configuration is sixteen bits, two bytes
`timescale 1ns/100ps
`default_nettype none
`include "tsiic_defs.svh"

// ============================================================
// Byte queue with valid/ready on both sides
module tsiic_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = `TSI_FIFO_DEPTH
) (
    input  wire logic             ref_clk_in,  // System clock
    input  wire logic             rst_in,      // Async reset, high
    input  wire logic             in_valid_in, // Fill side offers a word
    output logic                  in_ready_out,// Room for a word
    input  wire logic [WIDTH-1:0] in_data_in,  // Word to store
    output logic                  out_valid_out,// Word available
    input  wire logic             out_ready_in,// Drain side takes it
    output logic      [WIDTH-1:0] out_data_out // Oldest word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage
    logic [AW-1:0]    wr_q, wr_d;      // Write index
    logic [AW-1:0]    rd_q, rd_d;      // Read index
    logic [AW:0]      cnt_q, cnt_d;    // Fill level
    logic             put;             // Store this cycle
    logic             take;            // Release this cycle

    // Handshakes and next pointers
    always_comb begin
        put  = in_valid_in && (cnt_q != (AW+1)'(DEPTH));
        take = out_valid_out && out_ready_in;
        wr_d = put ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = take ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = (AW+1)'(cnt_q + (AW+1)'(put) - (AW+1)'(take));
    end

    // Pointer registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage, written without reset
    always_ff @(posedge ref_clk_in) begin
        if (put) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];
endmodule : tsiic_fifo

// ============================================================
// Top: two-wire slave and register file
module tsiic_port #(
    parameter int unsigned BUS_TIMEOUT_INTERVAL_CYCLES = `TSI_BUS_TIMEOUT_INTERVAL_US * `TSI_CLK_MHZ,
    parameter logic [15:0] MAKER_ID    = 16'h00a5,  // Arbitrary value
    parameter logic [15:0] PART_ID     = 16'h5a00   // Arbitrary value
) (
    input  wire logic        ref_clk_in,          // System clock
    input  wire logic        rst_in,              // Async reset, high
    input  wire logic        scl_in,              // Serial clock pin
    input  wire logic        sda_in,              // Serial data pin level
    output logic             sda_out,             // Data drive level
    output logic             sda_oe_out,          // Pulling data low
    input  wire logic        address_select_pin_0,// Address strap bit 0
    input  wire logic        address_select_pin_1,// Address strap bit 1
    input  wire logic        address_select_pin_2,// Address strap bit 2
    input  wire logic [15:0] temp_value_in,       // New conversion result
    input  wire logic        temp_valid_in,       // Result strobe
    output logic      [15:0] config_out,          // Configuration contents
    output logic             alert_out            // Limit excursion
);
    // ============================================================
    // Pin synchronisers
    logic [1:0] scl_s_q, sda_s_q;   // Two-stage capture
    logic       scl_p_q, sda_p_q;   // Previous settled level
    logic [2:0] strap_s1_q, strap_q;// Strap capture
    logic       scl_rise, scl_fall; // Clock edges
    logic       start_ev, stop_ev;  // Bus conditions

    // Synchronise pins
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_s_q    <= 2'h3;
            sda_s_q    <= 2'h3;
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
            strap_s1_q <= 3'h0;
            strap_q    <= 3'h0;
        end else begin
            scl_s_q    <= {scl_s_q[0], scl_in};
            sda_s_q    <= {sda_s_q[0], sda_in};
            scl_p_q    <= scl_s_q[1];
            sda_p_q    <= sda_s_q[1];
            strap_s1_q <= {address_select_pin_2, address_select_pin_1,
                           address_select_pin_0};
            strap_q    <= strap_s1_q;
        end
    end

    // Edge and condition detection
    always_comb begin
        scl_rise = scl_s_q[1] && !scl_p_q;
        scl_fall = !scl_s_q[1] && scl_p_q;
        start_ev = scl_s_q[1] && scl_p_q && sda_p_q && !sda_s_q[1];
        stop_ev  = scl_s_q[1] && scl_p_q && !sda_p_q && sda_s_q[1];
    end

    // ============================================================
    // Link state
    tsiic_pkg::tsiic_state_e st_q, st_d;      // Link state
    logic [2:0]   bit_q, bit_d;               // Bit within byte
    logic [2:0]   slot_q, slot_d;             // Byte within transaction
    logic [7:0]   sh_q, sh_d;                 // Shift register
    logic         rd_q, rd_d;                 // Read transaction
    logic         lo_q, lo_d;                 // Sending second byte
    logic         oe_q, oe_d;                 // Data line pull
    logic [15:0]  word_q, word_d;             // Read snapshot
    logic [31:0]  tcnt_q, tcnt_d;             // Cycles since clock edge
    logic         timeout;                    // Clock stuck
    logic         push;                       // Queue a byte
    logic         q_ready;                    // Queue has room
    logic [15:0]  rd_mux;                     // Selected register
    logic [7:0]   ptr_q, ptr_d;               // Register selector
    tsiic_pkg::tsiic_entry_s ent_in;          // Queued byte

    // Clock stuck detection
    assign timeout = (st_q != tsiic_pkg::TSI_ST_IDLE)
                     && (tcnt_q >= BUS_TIMEOUT_INTERVAL_CYCLES - 1);

    // Link next state; only the data line is ever driven
    always_comb begin
        st_d   = st_q;
        bit_d  = bit_q;
        slot_d = slot_q;
        sh_d   = sh_q;
        rd_d   = rd_q;
        lo_d   = lo_q;
        oe_d   = oe_q;
        word_d = word_q;
        push   = 1'b0;
        ent_in.kind = slot_q[1:0];
        ent_in.data = sh_q;
        tcnt_d = (scl_rise || scl_fall || st_q == tsiic_pkg::TSI_ST_IDLE)
                 ? 32'h0 : tcnt_q + 32'h1;
        if (start_ev) begin
            // New transaction, address byte first
            st_d   = tsiic_pkg::TSI_ST_RX;
            bit_d  = 3'h0;
            slot_d = `TSI_SLOT_ADDR;
            oe_d   = 1'b0;
        end else if (stop_ev || timeout) begin
            // End, abandon, or recover from stuck clock
            st_d = tsiic_pkg::TSI_ST_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                tsiic_pkg::TSI_ST_RX: begin
                    // Sample on rising clock, MSB first
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s_q[1]};
                        bit_d = 3'(bit_q + 3'h1);
                        if (bit_q == `TSI_BIT_LAST) begin
                            st_d = tsiic_pkg::TSI_ST_RX_DONE;
                        end
                    end
                end
                tsiic_pkg::TSI_ST_RX_DONE: begin
                    // Acknowledge goes out after clock falls
                    if (scl_fall) begin
                        if (slot_q == `TSI_SLOT_ADDR) begin
                            if (sh_q[7:1] == {`TSI_ADDR_HI, strap_q}) begin
                                oe_d   = 1'b1;
                                rd_d   = sh_q[0];
                                word_d = rd_mux;
                                st_d   = tsiic_pkg::TSI_ST_RX_ACK;
                            end else begin
                                st_d = tsiic_pkg::TSI_ST_IDLE;
                            end
                        end else if (slot_q == `TSI_SLOT_DROP) begin
                            oe_d = 1'b1;      // Extra bytes acked, dropped
                            st_d = tsiic_pkg::TSI_ST_RX_ACK;
                        end else if (q_ready) begin
                            push = 1'b1;
                            oe_d = 1'b1;
                            st_d = tsiic_pkg::TSI_ST_RX_ACK;
                        end else begin
                            // Queue full: withhold acknowledge
                            st_d = tsiic_pkg::TSI_ST_IDLE;
                        end
                    end
                end
                tsiic_pkg::TSI_ST_RX_ACK: begin
                    // Hold low through the ninth clock
                    if (scl_fall) begin
                        bit_d  = 3'h0;
                        slot_d = (slot_q == `TSI_SLOT_DROP) ? slot_q
                                 : 3'(slot_q + 3'h1);
                        if (slot_q == `TSI_SLOT_ADDR && rd_q) begin
                            st_d = tsiic_pkg::TSI_ST_TX;
                            sh_d = word_q[15:8];
                            oe_d = !word_q[15];
                            lo_d = 1'b0;
                        end else begin
                            st_d = tsiic_pkg::TSI_ST_RX;
                            oe_d = 1'b0;
                        end
                    end
                end
                tsiic_pkg::TSI_ST_TX: begin
                    // Change data only after clock falls
                    if (scl_fall) begin
                        bit_d = 3'(bit_q + 3'h1);
                        if (bit_q == `TSI_BIT_LAST) begin
                            oe_d = 1'b0;
                            st_d = tsiic_pkg::TSI_ST_TX_ACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = !sh_q[6];
                        end
                    end
                end
                tsiic_pkg::TSI_ST_TX_ACK: begin
                    // Master acknowledge decides on a second byte
                    if (scl_rise) begin
                        if (!sda_s_q[1] && !lo_q) begin
                            st_d = tsiic_pkg::TSI_ST_TX_NEXT;
                        end else begin
                            st_d = tsiic_pkg::TSI_ST_IDLE;
                        end
                    end
                end
                tsiic_pkg::TSI_ST_TX_NEXT: begin
                    // Low byte of the same register
                    if (scl_fall) begin
                        st_d  = tsiic_pkg::TSI_ST_TX;
                        sh_d  = word_q[7:0];
                        oe_d  = !word_q[7];
                        lo_d  = 1'b1;
                        bit_d = 3'h0;
                    end
                end
                default: begin
                    // Idle: released, wait for start
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Link registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q   <= tsiic_pkg::TSI_ST_IDLE;
            bit_q  <= 3'h0;
            slot_q <= `TSI_SLOT_ADDR;
            sh_q   <= 8'h00;
            rd_q   <= 1'b0;
            lo_q   <= 1'b0;
            oe_q   <= 1'b0;
            word_q <= `TSI_READ_NONE;
            tcnt_q <= 32'h0;
        end else begin
            st_q   <= st_d;
            bit_q  <= bit_d;
            slot_q <= slot_d;
            sh_q   <= sh_d;
            rd_q   <= rd_d;
            lo_q   <= lo_d;
            oe_q   <= oe_d;
            word_q <= word_d;
            tcnt_q <= tcnt_d;
        end
    end

    assign sda_oe_out = oe_q;
    assign sda_out    = `TSI_SDA_DRIVE;

    // ============================================================
    // Byte queue between link and registers
    logic [9:0]              q_data;    // Raw queue output
    logic                    q_valid;   // Entry waiting
    logic                    q_take;    // Register side ready
    tsiic_pkg::tsiic_entry_s ent_out;   // Queue output

    // Register side stalls while a read snapshot is taken
    assign q_take  = (st_q != tsiic_pkg::TSI_ST_RX_DONE);
    assign ent_out = tsiic_pkg::tsiic_entry_s'(q_data);

    tsiic_fifo #(
        .WIDTH ($bits(tsiic_pkg::tsiic_entry_s)),
        .DEPTH (`TSI_FIFO_DEPTH)
    ) u_queue (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (push),
        .in_ready_out  (q_ready),
        .in_data_in    (ent_in),
        .out_valid_out (q_valid),
        .out_ready_in  (q_take),
        .out_data_out  (q_data)
    );

    // ============================================================
    // Register file
    logic [15:0] cfg_q, cfg_d;     // Configuration
    logic [15:0] up_q, up_d;       // Upper boundary
    logic [15:0] lo_lim_q, lo_lim_d;// Lower boundary
    logic [15:0] crit_q, crit_d;   // Critical limit
    logic [15:0] amb_q, amb_d;     // Ambient temperature
    logic [7:0]  hold_q, hold_d;   // High byte waiting
    logic        alert_q, alert_d; // Excursion flag

    // Read selection from low pointer bits
    always_comb begin
        case (ptr_q[3:0])
            `TSI_PTR_CONFIG:  rd_mux = cfg_q;
            `TSI_PTR_UPPER:   rd_mux = up_q;
            `TSI_PTR_LOWER:   rd_mux = lo_lim_q;
            `TSI_PTR_CRIT:    rd_mux = crit_q;
            `TSI_PTR_AMBIENT: rd_mux = amb_q;
            `TSI_PTR_MAKER:   rd_mux = MAKER_ID;
            `TSI_PTR_PART:    rd_mux = PART_ID;
            default:          rd_mux = `TSI_READ_NONE;
        endcase
    end

    // Apply queued bytes, refresh ambient, compare limits
    always_comb begin
        ptr_d    = ptr_q;
        hold_d   = hold_q;
        cfg_d    = cfg_q;
        up_d     = up_q;
        lo_lim_d = lo_lim_q;
        crit_d   = crit_q;
        amb_d    = temp_valid_in ? temp_value_in : amb_q;
        if (q_valid && q_take) begin
            case (ent_out.kind)
                `TSI_KIND_PTR: ptr_d  = ent_out.data;
                `TSI_KIND_MSB: hold_d = ent_out.data;
                `TSI_KIND_LSB: begin
                    case (ptr_q[3:0])
                        `TSI_PTR_CONFIG: cfg_d    = {hold_q, ent_out.data};
                        `TSI_PTR_UPPER:  up_d     = {hold_q, ent_out.data};
                        `TSI_PTR_LOWER:  lo_lim_d = {hold_q, ent_out.data};
                        `TSI_PTR_CRIT:   crit_d   = {hold_q, ent_out.data};
                        default: begin
                            // Read-only or unused: ignored
                        end
                    endcase
                end
                default: begin
                    // Address slot never queued
                end
            endcase
        end
        alert_d = ($signed(amb_q[`TSI_TEMP_MSB:0]) > $signed(up_q[`TSI_TEMP_MSB:0]))
               || ($signed(amb_q[`TSI_TEMP_MSB:0]) < $signed(lo_lim_q[`TSI_TEMP_MSB:0]));
    end

    // Register file storage
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ptr_q    <= `TSI_PTR_RST;
            hold_q   <= 8'h00;
            cfg_q    <= `TSI_REG_RST;
            up_q     <= `TSI_REG_RST;
            lo_lim_q <= `TSI_REG_RST;
            crit_q   <= `TSI_REG_RST;
            amb_q    <= `TSI_REG_RST;
            alert_q  <= 1'b0;
        end else begin
            ptr_q    <= ptr_d;
            hold_q   <= hold_d;
            cfg_q    <= cfg_d;
            up_q     <= up_d;
            lo_lim_q <= lo_lim_d;
            crit_q   <= crit_d;
            amb_q    <= amb_d;
            alert_q  <= alert_d;
        end
    end

    assign config_out = cfg_q;
    assign alert_out  = alert_q;
endmodule : tsiic_port
`default_nettype wire

// ### rtl/tsiic_defs.svh
// Constants for the sensor two-wire slave port
`ifndef TSIIC_DEFS_SVH
`define TSIIC_DEFS_SVH

// ============================================================
// Slave address
`define TSI_ADDR_HI       4'h3
// ============================================================
// Register selector codes, low four pointer bits
`define TSI_PTR_CONFIG    4'h1
`define TSI_PTR_UPPER     4'h2
`define TSI_PTR_LOWER     4'h3
`define TSI_PTR_CRIT      4'h4
`define TSI_PTR_AMBIENT   4'h5
`define TSI_PTR_MAKER     4'h6
`define TSI_PTR_PART      4'h7
// ============================================================
// Reset values
`define TSI_PTR_RST       8'h00
`define TSI_REG_RST       16'h0000
`define TSI_READ_NONE     16'h0000
// ============================================================
// Byte slots of a transaction and queue entry kinds
`define TSI_SLOT_ADDR     3'h0
`define TSI_SLOT_LAST     3'h3
`define TSI_SLOT_DROP     3'h4
`define TSI_KIND_PTR      2'h1
`define TSI_KIND_MSB      2'h2
`define TSI_KIND_LSB      2'h3
`define TSI_BIT_LAST      3'h7
// ============================================================
// Timing
`define TSI_CLK_MHZ       32'd100
`define TSI_BUS_TIMEOUT_INTERVAL_US       32'd30
// ============================================================
// Limit field of temperature words, two's complement
`define TSI_TEMP_MSB      12
// ============================================================
// Byte queue depth and data drive level
`define TSI_FIFO_DEPTH    8
`define TSI_SDA_DRIVE     1'b0

`endif

// ### rtl/tsiic_pkg.sv
// Types shared by the sensor two-wire slave port
package tsiic_pkg;

    // ============================================================
    // Link state machine
    typedef enum logic [2:0] {
        TSI_ST_IDLE    = 3'b000,  // Released, waiting for start
        TSI_ST_RX      = 3'b001,  // Shifting in a byte
        TSI_ST_RX_DONE = 3'b010,  // Eighth bit in, decide acknowledge
        TSI_ST_RX_ACK  = 3'b011,  // Holding acknowledge low
        TSI_ST_TX      = 3'b100,  // Shifting out a byte
        TSI_ST_TX_ACK  = 3'b101,  // Sampling master acknowledge
        TSI_ST_TX_NEXT = 3'b110   // Waiting to load second byte
    } tsiic_state_e;

    // ============================================================
    // Received byte as queued to the register side
    typedef struct packed {
        logic [1:0] kind;  // Pointer, high byte or low byte
        logic [7:0] data;  // Byte as received
    } tsiic_entry_s;

endpackage : tsiic_pkg

// ### verification/tsiic_chk.sv
// Property checker for the sensor two-wire slave port
`timescale 1ns/100ps
`default_nettype none
module tsiic_chk #(parameter int unsigned BUS_TIMEOUT_INTERVAL_CYCLES = 200) (
    input wire logic        ref_clk_in, rst_in, scl_in, sda_out, sda_oe_out,
    input wire logic        temp_valid_in, alert_out,
    input wire logic [15:0] config_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ============================================================
    // Cycles the drive stood while the serial clock stood still
    logic [15:0] hold_q, hold_d;
    logic        scl_q;
    always_comb hold_d = (sda_oe_out && scl_in == scl_q) ? hold_q + 16'h0001 : 16'h0000;
    always_ff @(posedge ref_clk_in or posedge rst_in)
        if (rst_in) {hold_q, scl_q} <= 17'h00001;
        else {hold_q, scl_q} <= {hold_d, scl_in};
    // ============================================================
    // Drive only pulls low, changes only in clock low
    a_drive_low: assert property (sda_oe_out |-> !sda_out) else $error("data high");
    a_rise_on_low: assert property ($rose(sda_oe_out) |-> !$past(scl_in, 2) && $past(scl_in, 5))
        else $error("drive began off clock low");
    a_fall_on_low: assert property ($fell(sda_oe_out) |-> !$past(scl_in, 2))
        else $error("drive ended off clock low");
    a_steady_high: assert property (scl_in && $past(scl_in, 3) && !$past(scl_in, 7)
        |-> $stable(sda_oe_out)) else $error("drive moved in clock high");
    a_bit_width: assert property ($rose(sda_oe_out) |=> sda_oe_out [*6])
        else $error("drive too short");
    a_drive_bound: assert property (hold_q <= BUS_TIMEOUT_INTERVAL_CYCLES + 8) else $error("no time-out");
    a_cfg_in_ack: assert property ($changed(config_out) |-> sda_oe_out || $past(sda_oe_out))
        else $error("config changed off acknowledge");
    a_alert_cause: assert property ($changed(alert_out)
        |-> $past(temp_valid_in, 2) || $past(sda_oe_out, 2)) else $error("alert without cause");
    // Main scenarios reached
    c_ack: cover property ($rose(sda_oe_out));
    c_cfg: cover property ($changed(config_out));
    c_alert: cover property ($rose(alert_out));
endmodule : tsiic_chk
bind tsiic_port tsiic_chk #(.BUS_TIMEOUT_INTERVAL_CYCLES(BUS_TIMEOUT_INTERVAL_CYCLES)) u_chk (.ref_clk_in, .rst_in, .scl_in,
    .sda_out, .sda_oe_out, .temp_valid_in, .alert_out, .config_out);
`default_nettype wire

// ### verification/tsiic_master.sv
// Two-wire bus master model facing the sensor slave port
`timescale 1ns/100ps
`default_nettype none
module tsiic_master (
    input  wire logic ref_clk_in,
    input  wire logic sda_in,
    output var logic  scl_out,
    output var logic  sda_low_out
);
    // Idle bus: clock high, data released to pull-up
    initial {scl_out, sda_low_out} = 2'b10;
    // Set data and clock, hold n system clocks
    task automatic step(input logic s, input logic c, input int n);
        sda_low_out = !s;
        scl_out = c;
        repeat (n) @(negedge ref_clk_in);
    endtask : step
    // Start or repeated start from either clock level
    task automatic start();
        step(!sda_low_out, scl_out, 2);
        step(1'b1, scl_out, 2);
        step(1'b1, 1'b1, 4);
        step(1'b0, 1'b1, 4);
        scl_out = 1'b0;
    endtask : start
    // Stop closes a transfer
    task automatic stop();
        step(!sda_low_out, 1'b0, 2);
        step(1'b0, 1'b0, 2);
        step(1'b0, 1'b1, 4);
        step(1'b1, 1'b1, 4);
    endtask : stop
    // One bit; data moves only in clock low, read at end of high
    task automatic bitx(input logic b, output logic r);
        step(!sda_low_out, 1'b0, 2);
        step(b, 1'b0, 2);
        step(b, 1'b1, 4);
        r = sda_in;
        scl_out = 1'b0;
    endtask : bitx
    // Byte MSB first, then the ninth clock
    task automatic xfer(input logic [7:0] tx, input logic nak, output logic [7:0] rx,
                        output logic acked);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
        bitx(nak, a);
        acked = !a;
    endtask : xfer
endmodule : tsiic_master
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the sensor two-wire slave port
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [15:0] MAKER = 16'h0c3a, PART = 16'h0071; // Arbitrary values
    logic ref_clk_in = 1'b0, rst_in = 1'b1, temp_valid_in = 1'b0, scl_in, m_low, sda_in;
    logic sda_out, sda_oe_out, alert_out, address_select_pin_0, address_select_pin_1;
    logic address_select_pin_2;
    logic [15:0] temp_value_in = 16'h0000, config_out, res, exp_q [$];
    logic [15:0] regs [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, MAKER, PART};
    logic [7:0]  ptr = 8'h00;
    logic [6:0]  me;
    string       name_q [$];
    event        res_ev;
    int          fail_count = 0, comparisons = 0, cycles = 0;
    assign sda_in = (sda_oe_out ? sda_out : 1'b1) & !m_low; // Pull-up wire
    always #5 ref_clk_in = !ref_clk_in;
    tsiic_port #(.BUS_TIMEOUT_INTERVAL_CYCLES(200), .MAKER_ID(MAKER), .PART_ID(PART)) uut (.ref_clk_in, .rst_in,
        .scl_in, .sda_in, .sda_out, .sda_oe_out, .address_select_pin_0, .address_select_pin_1,
        .address_select_pin_2, .temp_value_in, .temp_valid_in, .config_out, .alert_out);
    tsiic_master m (.ref_clk_in, .sda_in, .scl_out(scl_in), .sda_low_out(m_low));
    task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : check
    // Watcher: oldest note against each result
    always @(res_ev) check(name_q.pop_front(), exp_q.pop_front(), res);
    task automatic note(input string n, input logic [15:0] e, input logic [15:0] v);
        name_q.push_back(n);
        exp_q.push_back(e);
        res = v;
        ->res_ev;
        #1;
    endtask : note
    function automatic logic alert_exp();
        return $signed(regs[5][12:0]) > $signed(regs[2][12:0]) ||
               $signed(regs[5][12:0]) < $signed(regs[3][12:0]);
    endfunction : alert_exp
    // One transaction; writes carry pointer and both data bytes
    task automatic txn(input logic [6:0] a, input logic rd, input logic [7:0] p,
                       input logic [15:0] d);
        logic [7:0] hi, lo;
        logic       k;
        logic [2:0] ka;
        m.start();
        m.xfer({a, rd}, 1'b1, hi, k);
        note("address ack", 16'(a == me), 16'(k));
        if (a == me && rd) begin
            m.xfer(8'hff, 1'b0, hi, k);
            m.xfer(8'hff, 1'b1, lo, k);
            note("read word", regs[ptr[2:0]], {hi, lo});
        end else if (a == me) begin
            m.xfer(p, 1'b1, hi, ka[2]);
            m.xfer(d[15:8], 1'b1, hi, ka[1]);
            m.xfer(d[7:0], 1'b1, hi, ka[0]);
            note("write acks", 16'h0007, 16'(ka));
            ptr = p;
            if (p inside {[8'h01:8'h04]}) regs[p[2:0]] = d;
        end
        m.stop();
        note("config", regs[1], config_out);
        note("alert", 16'(alert_exp()), 16'(alert_out));
    endtask : txn
    // New conversion result, one-cycle strobe
    task automatic ambient(input logic [15:0] v);
        @(negedge ref_clk_in);
        {temp_value_in, temp_valid_in} = {v, 1'b1};
        @(negedge ref_clk_in);
        temp_valid_in = 1'b0;
        repeat (2) @(negedge ref_clk_in);
        regs[5] = v;
        note("alert", 16'(alert_exp()), 16'(alert_out));
    endtask : ambient
    task automatic results();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // Hang guard
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        logic [7:0] hi;
        logic       k;
        void'($urandom(32'h12de));
        {address_select_pin_2, address_select_pin_1, address_select_pin_0} = 3'($urandom);
        me = {4'h3, address_select_pin_2, address_select_pin_1, address_select_pin_0};
        repeat (12) @(negedge ref_clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge ref_clk_in);
        txn(me ^ 7'h04, 1'b0, 8'h01, 16'h1ffc);
        txn(me ^ 7'h40, 1'b0, 8'h01, 16'h1ffc);
        $display("test address done");
        ambient(16'($urandom));
        for (int p = 0; p < 8; p++) begin
            txn(me, 1'b0, 8'(p), 16'($urandom) & 16'h1ffc);
            txn(me, 1'b1, 8'h00, 16'h0000);
        end
        $display("test registers done");
        ambient(16'h0fff);
        ambient(16'h1000);
        $display("test alert done");
        m.start();
        m.xfer({me, 1'b0}, 1'b1, hi, k);
        for (int i = 0; i < 4; i++) m.bitx(i[0], k);
        txn(me, 1'b1, 8'h00, 16'h0000);
        m.start();
        m.xfer({me, 1'b1}, 1'b1, hi, k);
        m.step(1'b1, 1'b0, 4);
        note("data driven", 16'h0000, 16'(sda_in));
        m.step(1'b1, 1'b0, 240);
        note("data released", 16'h0001, 16'(sda_in));
        m.stop();
        txn(me, 1'b1, 8'h00, 16'h0000);
        $display("test abort done");
        results();
    end
endmodule : testbench
`default_nettype wire
